// [bench/iosg_cpu_model.sv]
// Processor-side model that runs slow I/O cycles through the glue block
`timescale 1ns/1ps
module iosg_cpu_model
    import iosg_pkg::*;
(
    input wire logic clock,
    input wire logic start,
    input wire logic write,
    input wire iosg_bus_t bus,
    output iosg_req_t io_req,
    output logic done,
    output int n_strobe,
    output int n_stall,
    output int n_latch,
    output logic quiet_ok
);
    logic rd_prev;
    logic rd_low;
    logic wr_low;

    initial
    begin
        io_req = '0;
        done = 1'b0;
        quiet_ok = 1'b0;
        rd_prev = 1'b1;
        rd_low = 1'b0;
        wr_low = 1'b0;
    end

    // Hold the select until the stall ends, counting strobe and stall cycles
    always @(posedge clock)
    begin
        #1;
        rd_low = (bus.io_read_strobe_n === 1'b0);
        wr_low = (bus.io_write_strobe_n === 1'b0);
        if (!start)
            done = 1'b0;
        if (io_req.io_select)
        begin
            // Only the strobe that matches the access may be low
            if (io_req.write ? (wr_low && !rd_low) : (rd_low && !wr_low))
                n_strobe++;
            // Read data latch closes as the read strobe ends
            if (rd_prev === 1'b0 && !rd_low)
                n_latch++;
            if (bus.cpu_stall_n === 1'b0)
                n_stall++;
            else if (n_stall > 0)
            begin
                // Nothing but quiet may sit on the bus in the sample cycle
                quiet_ok = bus.bus_quiet && bus.io_read_strobe_n && bus.io_write_strobe_n;
                io_req = '0;
                done = 1'b1;
            end
        end
        else if (start && !done)
        begin
            io_req = {1'b1, write};
            n_strobe = 0;
            n_stall = 0;
            n_latch = 0;
        end
        rd_prev = bus.io_read_strobe_n;
    end
endmodule

// [bench/iosg_glue_tb.sv]
// Self-checking bench for the I/O subsystem glue block
`timescale 1ns/1ps
module iosg_glue_tb
    import iosg_pkg::*;
;
    localparam int POR = 8;
    localparam int NW = WAIT_STATES;
    logic clock = 0, arst_n = 0, reset_switch_n = 1, test_reset_n = 1, tester_stall_n = 1;
    logic scc_irq_n = 1, timer_irq_n = 1, irq_route_link = 0, multi_purpose_out = 0;
    logic boot_mem_req = 0, start = 0, write = 0, done, quiet_ok;
    logic tpoc_n, scan_n, rst_hi, rst_lo, fiq_n, irq_n, led;
    iosg_req_t io_req;
    iosg_bus_t bus;
    int n_strobe, n_stall, n_latch, n_errors = 0, n_checks = 0;

    // Free-running clock
    always #5 clock = ~clock;

    iosg_glue #(.POR_LEN(POR), .N_WAIT(NW)) i_iosg_glue (.clock(clock), .arst_n(arst_n),
        .reset_switch_n(reset_switch_n), .test_reset_n(test_reset_n),
        .tester_stall_n(tester_stall_n), .scc_irq_n(scc_irq_n), .timer_irq_n(timer_irq_n),
        .irq_route_link(irq_route_link), .multi_purpose_out(multi_purpose_out),
        .io_req(io_req), .boot_mem_req(boot_mem_req), .test_power_on_clear_n(tpoc_n),
        .scan_reset_n(scan_n), .system_reset_hi(rst_hi), .system_reset_lo(rst_lo),
        .fast_irq_n(fiq_n), .normal_irq_n(irq_n), .bus(bus), .led_on(led));

    iosg_cpu_model i_iosg_cpu_model (.clock(clock), .start(start), .write(write), .bus(bus),
        .io_req(io_req), .done(done), .n_strobe(n_strobe), .n_stall(n_stall),
        .n_latch(n_latch), .quiet_ok(quiet_ok));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(string name, logic exp, logic got);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic chk_n(string name, int exp, int got);
        n_checks++;
        if (got != exp)
        begin
            n_errors++;
            $display("unexpected %s expected %0d seen %0d", name, exp, got);
        end
    endtask

    task automatic tick(int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic give_verdict;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic wait_sys;
        for (int i = 0; i < 100 && rst_lo !== 1'b1; i++)
            tick(1);
        chk("system_reset_lo", 1'b1, rst_lo);
        if (rst_lo !== 1'b1)
            give_verdict();
    endtask

    task automatic access(logic w);
        // A finished flag left from the last access must clear first
        for (int i = 0; i < 100 && done !== 1'b0; i++)
            tick(1);
        chk("done", 1'b0, done);
        if (done !== 1'b0)
            give_verdict();
        start = 1'b1;
        write = w;
        for (int i = 0; i < 100 && done !== 1'b1; i++)
            tick(1);
        start = 1'b0;
        chk("done", 1'b1, done);
        if (done !== 1'b1)
            give_verdict();
        else
            tick(1);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        tick(5);
        chk("scan_reset_n", 1'b0, scan_n);
        chk("test_power_on_clear_n", 1'b0, tpoc_n);
        chk("system_reset_hi", 1'b1, rst_hi);
        chk("system_reset_lo", 1'b0, rst_lo);
        chk("led_on", 1'b0, led);
        arst_n = 1'b1;
        tick(2);
        chk("test_power_on_clear_n", 1'b0, tpoc_n);
        wait_sys();
        chk("test_power_on_clear_n", 1'b1, tpoc_n);
        chk("scan_reset_n", 1'b1, scan_n);
        chk("system_reset_hi", 1'b0, rst_hi);
    endtask

    task automatic t_test_reset;
        test_reset_n = 1'b0;
        tick(4);
        chk("scan_reset_n", 1'b0, scan_n);
        chk("system_reset_lo", 1'b1, rst_lo);
        test_reset_n = 1'b1;
        tick(4);
        chk("scan_reset_n", 1'b1, scan_n);
    endtask

    task automatic t_switch;
        reset_switch_n = 1'b0;
        tick(4);
        chk("system_reset_hi", 1'b1, rst_hi);
        chk("system_reset_lo", 1'b0, rst_lo);
        chk("scan_reset_n", 1'b1, scan_n);
        reset_switch_n = 1'b1;
        wait_sys();
    endtask

    task automatic t_irq;
        for (int l = 0; l < 2; l++)
            for (int s = 0; s < 2; s++)
            begin
                irq_route_link = l[0];
                scc_irq_n = (s != 0);
                timer_irq_n = (s != 1);
                tick(4);
                chk("fast_irq_n", l[0], fiq_n);
                chk("normal_irq_n", !l[0], irq_n);
                scc_irq_n = 1'b1;
                timer_irq_n = 1'b1;
                tick(4);
                chk("fast_irq_n", 1'b1, fiq_n);
                chk("normal_irq_n", 1'b1, irq_n);
            end
        irq_route_link = 1'b0;
    endtask

    task automatic t_led;
        for (int v = 0; v < 2; v++)
        begin
            multi_purpose_out = v[0];
            tick(4);
            chk("led_on", !v[0], led);
        end
    endtask

    task automatic t_cycles;
        for (int w = 0; w < 2; w++)
        begin
            access(w[0]);
            chk_n("strobe cycles", NW + 1, n_strobe);
            chk_n("stall cycles", NW + 2, n_stall);
            chk("bus quiet", 1'b1, quiet_ok);
            chk_n("read latch closes", (w == 0) ? 1 : 0, n_latch);
        end
        boot_mem_req = 1'b1;
        tick(1);
        boot_mem_req = 1'b0;
        chk("io_read_strobe_n", 1'b0, bus.io_read_strobe_n);
        tick(NW + 5);
        chk("cpu_stall_n", 1'b1, bus.cpu_stall_n);
    endtask

    task automatic t_stall;
        tester_stall_n = 1'b0;
        write = 1'b0;
        start = 1'b1;
        tick(NW + 8);
        chk("cpu_stall_n", 1'b0, bus.cpu_stall_n);
        tester_stall_n = 1'b1;
        access(1'b0);
        chk("strobe stretched", 1'b1, n_strobe > NW + 1);
    endtask

    task automatic t_abort;
        tick(1);
        start = 1'b1;
        write = 1'b0;
        tick(3);
        arst_n = 1'b0;
        tick(1);
        chk("io_read_strobe_n", 1'b1, bus.io_read_strobe_n);
        chk("cpu_stall_n", 1'b1, bus.cpu_stall_n);
        start = 1'b0;
        arst_n = 1'b1;
        wait_sys();
        access(1'b0);
        chk_n("strobe cycles", NW + 1, n_strobe);
        // Switch pressed while a read strobe is still running
        tick(1);
        start = 1'b1;
        reset_switch_n = 1'b0;
        tick(4);
        chk("io_read_strobe_n", 1'b1, bus.io_read_strobe_n);
        chk("cpu_stall_n", 1'b1, bus.cpu_stall_n);
        reset_switch_n = 1'b1;
        start = 1'b0;
        wait_sys();
        access(1'b0);
        chk_n("strobe cycles", NW + 1, n_strobe);
    endtask

    // Main sequence
    initial
    begin
        t_reset();
        t_test_reset();
        t_switch();
        t_irq();
        t_led();
        t_cycles();
        t_stall();
        t_abort();
        give_verdict();
    end
endmodule

// [common/iosg_pkg.sv]
// Package of constants and carrier types for the I/O subsystem glue block
package iosg_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int POR_PULSE_US = 10;
    localparam int POR_CYCLES = POR_PULSE_US * CLK_MHZ;
    localparam int WAIT_STATES = 3;
    localparam int CNT_W = 16;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

    // ------------------------------------------------------------
    // I/O cycle sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        IOSG_DECODE,
        IOSG_STROBE,
        IOSG_RELEASE,
        IOSG_SAMPLE
    } iosg_state_t;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic io_select;
        logic write;
    } iosg_req_t;

    typedef struct packed {
        logic cpu_stall_n;
        logic io_read_strobe_n;
        logic io_write_strobe_n;
        logic bus_quiet;
    } iosg_bus_t;

endpackage

// [rtl/iosg_glue.sv]
// Reset generation, slow I/O strobe sequencing and interrupt routing glue
`timescale 1ns/1ps
module iosg_glue
    import iosg_pkg::*;
#(
    parameter int POR_LEN = POR_CYCLES,
    parameter int N_WAIT = WAIT_STATES
)
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic reset_switch_n,
    input wire logic test_reset_n,
    input wire logic tester_stall_n,
    input wire logic scc_irq_n,
    input wire logic timer_irq_n,
    input wire logic irq_route_link,
    input wire logic multi_purpose_out,
    input wire iosg_req_t io_req,
    input wire logic boot_mem_req,
    output logic test_power_on_clear_n,
    output logic scan_reset_n,
    output logic system_reset_hi,
    output logic system_reset_lo,
    output logic fast_irq_n,
    output logic normal_irq_n,
    output iosg_bus_t bus,
    output logic led_on
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    localparam int N_SYNC = 7;
    logic [N_SYNC-1:0] raw_in;
    logic [N_SYNC-1:0] sync1_q;
    logic [N_SYNC-1:0] sync2_q;
    assign raw_in = {reset_switch_n, test_reset_n, tester_stall_n, scc_irq_n,
                     timer_irq_n, irq_route_link, multi_purpose_out};

    // Two-stage synchronisers, idle-high except link and output pin
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sync1_q <= 7'h7c;
            sync2_q <= 7'h7c;
        end
        else
        begin
            sync1_q <= raw_in;
            sync2_q <= sync1_q;
        end
    end

    logic sw_n_s;
    logic trst_n_s;
    logic stall_n_s;
    logic scc_n_s;
    logic tmr_n_s;
    logic link_s;
    logic mpo_s;
    assign {sw_n_s, trst_n_s, stall_n_s, scc_n_s, tmr_n_s, link_s, mpo_s} = sync2_q;

    // ------------------------------------------------------------
    // Power-on and manual reset monostables
    // ------------------------------------------------------------
    localparam logic [CNT_W-1:0] POR_LOAD = CNT_W'(POR_LEN);
    logic [CNT_W-1:0] sys_cnt_q;
    logic [CNT_W-1:0] sys_cnt_d;
    logic [CNT_W-1:0] tpor_cnt_q;
    logic [CNT_W-1:0] tpor_cnt_d;
    logic sys_active;
    logic tpor_active;

    // Switch retriggers only the system monostable, not the scan one
    assign sys_active = (sys_cnt_q != CNT_ZERO);
    assign tpor_active = (tpor_cnt_q != CNT_ZERO);
    assign sys_cnt_d = !sw_n_s ? POR_LOAD : (sys_active ? sys_cnt_q - CNT_ONE : CNT_ZERO);
    assign tpor_cnt_d = tpor_active ? tpor_cnt_q - CNT_ONE : CNT_ZERO;

    // Both monostables start loaded at power-up
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sys_cnt_q <= POR_LOAD;
            tpor_cnt_q <= POR_LOAD;
        end
        else
        begin
            sys_cnt_q <= sys_cnt_d;
            tpor_cnt_q <= tpor_cnt_d;
        end
    end

    // Reset outputs; scan reset ignores the system reset
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            system_reset_hi <= 1'b1;
            system_reset_lo <= 1'b0;
            test_power_on_clear_n <= 1'b0;
            scan_reset_n <= 1'b0;
        end
        else
        begin
            system_reset_hi <= sys_active;
            system_reset_lo <= !sys_active;
            test_power_on_clear_n <= !tpor_active;
            scan_reset_n <= !tpor_active && trst_n_s;
        end
    end

    // ------------------------------------------------------------
    // Interrupt routing
    // ------------------------------------------------------------
    logic shared_irq_n;
    assign shared_irq_n = scc_n_s & tmr_n_s; // wired-OR of active-low sources

    // Link high steers the shared request to the normal input
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            fast_irq_n <= 1'b1;
            normal_irq_n <= 1'b1;
        end
        else
        begin
            fast_irq_n <= link_s ? 1'b1 : shared_irq_n;
            normal_irq_n <= link_s ? shared_irq_n : 1'b1;
        end
    end

    // ------------------------------------------------------------
    // I/O cycle sequencer
    // ------------------------------------------------------------
    iosg_state_t state_q;
    iosg_state_t state_d;
    logic [CNT_W-1:0] ws_q;
    logic [CNT_W-1:0] ws_d;
    logic write_q;
    logic write_d;
    logic start;
    logic ws_done;
    localparam logic [CNT_W-1:0] WS_LOAD = CNT_W'(N_WAIT);

    // Boot memory and controller accesses share one sequence
    assign start = io_req.io_select || boot_mem_req;
    assign ws_done = (ws_q == CNT_ZERO);

    // Next-state: strobe with waits, release, quiet sample, decode
    always_comb
    begin
        state_d = state_q;
        ws_d = ws_q;
        write_d = write_q;
        unique case (state_q)
            IOSG_DECODE:
            begin
                if (start)
                begin
                    state_d = IOSG_STROBE;
                    ws_d = WS_LOAD;
                    write_d = io_req.write;
                end
            end
            IOSG_STROBE:
            begin
                if (ws_done && stall_n_s)
                    state_d = IOSG_RELEASE;
                else if (!ws_done)
                    ws_d = ws_q - CNT_ONE;
            end
            IOSG_RELEASE: state_d = IOSG_SAMPLE;
            IOSG_SAMPLE: state_d = IOSG_DECODE;
            default: state_d = IOSG_DECODE;
        endcase
    end

    // Sequencer registers; reset abandons any cycle
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_q <= IOSG_DECODE;
            ws_q <= CNT_ZERO;
            write_q <= 1'b0;
        end
        else if (sys_active)
        begin
            state_q <= IOSG_DECODE;
            ws_q <= CNT_ZERO;
            write_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            ws_q <= ws_d;
            write_q <= write_d;
        end
    end

    // ------------------------------------------------------------
    // Bus strobes, stall and LED
    // ------------------------------------------------------------
    iosg_bus_t bus_d;
    iosg_state_t seq_next;
    logic seq_strobe;
    // Outputs follow the state the sequencer really enters; reset shows idle decode
    assign seq_next = sys_active ? IOSG_DECODE : state_d;
    assign seq_strobe = (seq_next == IOSG_STROBE);
    assign bus_d.io_read_strobe_n = !(seq_strobe && !write_d);
    assign bus_d.io_write_strobe_n = !(seq_strobe && write_d);
    assign bus_d.cpu_stall_n = !(seq_strobe || seq_next == IOSG_RELEASE) && stall_n_s;
    assign bus_d.bus_quiet = (seq_next == IOSG_SAMPLE);

    // Registered bus outputs and inverted LED drive
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bus <= '{cpu_stall_n: 1'b1, io_read_strobe_n: 1'b1,
                     io_write_strobe_n: 1'b1, bus_quiet: 1'b0};
            led_on <= 1'b0;
        end
        else
        begin
            bus <= bus_d;
            led_on <= !sys_active && !mpo_s;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_sample_then_decode;
        @(posedge clock) disable iff (!arst_n)
        (state_q == IOSG_SAMPLE && !sys_active) |=> (state_q == IOSG_DECODE);
    endproperty
    a_sample_then_decode: assert property (p_sample_then_decode)
        else $error("sample cycle not followed by decode");

    property p_release_then_sample;
        @(posedge clock) disable iff (!arst_n)
        (state_q == IOSG_RELEASE && !sys_active) |=> (state_q == IOSG_SAMPLE);
    endproperty
    a_release_then_sample: assert property (p_release_then_sample)
        else $error("release not followed by sample");

    property p_strobe_off_in_sample;
        @(posedge clock) disable iff (!arst_n)
        bus.bus_quiet |-> (bus.io_read_strobe_n && bus.io_write_strobe_n);
    endproperty
    a_strobe_off_in_sample: assert property (p_strobe_off_in_sample)
        else $error("strobe active during sample cycle");

    property p_reset_to_decode;
        @(posedge clock) disable iff (!arst_n)
        sys_active |=> (state_q == IOSG_DECODE);
    endproperty
    a_reset_to_decode: assert property (p_reset_to_decode)
        else $error("sequencer not idle under reset");

    property p_reset_pair;
        @(posedge clock) disable iff (!arst_n)
        system_reset_hi != system_reset_lo;
    endproperty
    a_reset_pair: assert property (p_reset_pair)
        else $error("reset outputs not complementary");

    property p_switch_retrigger;
        @(posedge clock) disable iff (!arst_n)
        !sw_n_s |=> ##1 system_reset_hi;
    endproperty
    a_switch_retrigger: assert property (p_switch_retrigger)
        else $error("switch did not assert reset");

    property p_scan_reset_indep;
        @(posedge clock) disable iff (!arst_n)
        (!trst_n_s && !sys_active && !$past(sys_active)) |=> (!scan_reset_n && system_reset_lo);
    endproperty
    a_scan_reset_indep: assert property (p_scan_reset_indep)
        else $error("scan reset not independent");

    property p_tpor_at_start;
        @(posedge clock) disable iff (!arst_n)
        tpor_active |=> !test_power_on_clear_n;
    endproperty
    a_tpor_at_start: assert property (p_tpor_at_start)
        else $error("test power-on clear missing");

    property p_fast_route;
        @(posedge clock) disable iff (!arst_n)
        !link_s |=> (fast_irq_n == $past(shared_irq_n)) && normal_irq_n;
    endproperty
    a_fast_route: assert property (p_fast_route)
        else $error("fast interrupt routing wrong");

    property p_normal_route;
        @(posedge clock) disable iff (!arst_n)
        link_s |=> (normal_irq_n == $past(shared_irq_n)) && fast_irq_n;
    endproperty
    a_normal_route: assert property (p_normal_route)
        else $error("normal interrupt routing wrong");

    property p_wait_states;
        @(posedge clock) disable iff (!arst_n)
        (state_q == IOSG_DECODE && start && !sys_active) |=> !bus.cpu_stall_n;
    endproperty
    a_wait_states: assert property (p_wait_states)
        else $error("no wait state on I/O access");

    property p_led_reset;
        @(posedge clock) disable iff (!arst_n)
        sys_active |=> !led_on;
    endproperty
    a_led_reset: assert property (p_led_reset)
        else $error("LED lit during reset");

endmodule
